// ===== hdl/tcmu_cfg.svh
`ifndef TCMU_CFG_SVH
`define TCMU_CFG_SVH

// ****************************************************************
// Field widths and encodings
// ****************************************************************
`define TCMU_UNITS         4
`define TCMU_CNT_W         16
`define TCMU_SEL_W         4
`define TCMU_SEL_OFF       4'h0
`define TCMU_SEL_TOGGLE    4'h2
`define TCMU_SEL_SET       4'h8
`define TCMU_SEL_CLEAR     4'h9
`define TCMU_SEL_SOFT_INT  4'hA
`define TCMU_SEL_SPECIAL   4'hB
`define TCMU_LATCH_RESET   1'h0
`define TCMU_CTRL_RESET    4'h0

`endif

// ===== hdl/tcmu_pkg.sv
package tcmu_pkg;

    // ************************************************************
    // Types shared by the top and the per-unit slice
    // ************************************************************
    typedef logic [15:0] tcmu_count_t;
    typedef logic [3:0]  tcmu_sel_t;

    // Software write port of one unit.
    typedef struct packed
    {
        logic        value_write;
        tcmu_count_t value;
        logic        control_write;
        tcmu_sel_t   control;
    } tcmu_sw_t;

    // What one unit reports on a match.
    typedef struct packed
    {
        logic pin_level;
        logic pin_owned;
        logic special_event;
    } tcmu_unit_out_t;

    typedef enum logic [1:0]
    {
        TCMU_PIN_IDLE,
        TCMU_PIN_DRIVE,
        TCMU_PIN_RELEASE
    } tcmu_pin_state_t;

endpackage

// ===== hdl/tcmu_slice.sv
`timescale 1ns/1ns
`include "tcmu_cfg.svh"

// One compare unit: value, select field, output latch and match flag.
module tcmu_slice
    import tcmu_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire tcmu_pkg::tcmu_sw_t  sw,
    input  wire tcmu_pkg::tcmu_count_t timer_count,
    input  wire logic                flag_clear,
    output logic                     match,
    output logic                     match_flag,
    output tcmu_pkg::tcmu_sel_t      select,
    output tcmu_pkg::tcmu_count_t    value,
    output logic                     out_latch
);

    // ************************************************************
    // Match decode
    // ************************************************************

    // Equality is checked on every clock, not only on timer ticks.
    wire logic    equal;
    wire logic    sel_pin;
    wire logic    next_out_latch;
    wire logic    hit;
    logic         match_d;
    assign equal   = (value == timer_count);
    assign match   = equal && (select != `TCMU_SEL_OFF);
    // The count stands for several clocks per tick, so act only once.
    assign hit     = match && !match_d;
    // Only toggle, set and clear drive the pin.
    assign sel_pin = (select == `TCMU_SEL_TOGGLE) ||
                     (select == `TCMU_SEL_SET) ||
                     (select == `TCMU_SEL_CLEAR);

    // Pin action picked by the select field on a match.
    assign next_out_latch =
        (!hit || !sel_pin)              ? out_latch :
        (select == `TCMU_SEL_TOGGLE)    ? ~out_latch :
        (select == `TCMU_SEL_SET)       ? 1'b1 : 1'b0;

    // ************************************************************
    // State
    // ************************************************************

    // A control write of zero clears the compare latch, and with it the output pin.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            value      <= '0;
            select     <= `TCMU_CTRL_RESET;
            out_latch  <= `TCMU_LATCH_RESET;
            match_flag <= 1'b0;
            match_d    <= 1'b0;
        end
        else
        begin
            match_d <= match;
            if (sw.value_write)
                value <= sw.value;
            if (sw.control_write)
                select <= sw.control;
            if (sw.control_write && sw.control == `TCMU_CTRL_RESET)
                out_latch <= `TCMU_LATCH_RESET;
            else
                out_latch <= next_out_latch;
            // Set wins over clear so no match is lost.
            if (hit)
                match_flag <= 1'b1;
            else if (flag_clear)
                match_flag <= 1'b0;
        end
    end

endmodule

// ===== hdl/tcmu_top.sv
`timescale 1ns/1ns
`include "tcmu_cfg.svh"

module tcmu_top
    import tcmu_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           reset,
    input  wire tcmu_pkg::tcmu_sw_t [3:0]       sw,
    input  wire logic [3:0]                     flag_clear,
    input  wire tcmu_pkg::tcmu_count_t          timer_count,
    input  wire logic                           timer_tick,
    input  wire logic                           converter_enable,
    output logic [3:0]                          compare_match_flag,
    output logic [3:0]                          compare_output_pin,
    output logic [3:0]                          pin_owned,
    output logic                                special_event,
    output logic                                timer_reset,
    output logic                                converter_start,
    output logic                                overflow_suppress
);
    import tcmu_pkg::*;

    // ************************************************************
    // Unit instances
    // ************************************************************
    logic [3:0]      match;
    logic [3:0]      latch;
    tcmu_sel_t [3:0] select;
    tcmu_count_t [3:0] value;

    // Four identical slices share only the clock, the reset and the timer count.
    genvar g;
    generate
        for (g = 0; g < `TCMU_UNITS; g++)
        begin : unit
            tcmu_slice u_slice
            (
                .clk         (clk),
                .reset       (reset),
                .sw          (sw[g]),
                .timer_count (timer_count),
                .flag_clear  (flag_clear[g]),
                .match       (match[g]),
                .match_flag  (compare_match_flag[g]),
                .select      (select[g]),
                .value       (value[g]),
                .out_latch   (latch[g])
            );
        end
    endgenerate

    // ************************************************************
    // Pin ownership and special event
    // ************************************************************
    logic [3:0] spec_match;
    logic       pending;
    logic       still_equal;

    // The pin belongs to the unit only in toggle, set or clear modes.
    always_comb
    begin
        for (int i = 0; i < `TCMU_UNITS; i++)
        begin
            pin_owned[i]  = (select[i] == `TCMU_SEL_TOGGLE) ||
                            (select[i] == `TCMU_SEL_SET) ||
                            (select[i] == `TCMU_SEL_CLEAR);
            spec_match[i] = match[i] &&
                            (select[i] == `TCMU_SEL_SPECIAL);
        end
    end

    assign compare_output_pin = latch;

    // Trigger is combinational so it rises in the match cycle itself.
    assign special_event = |spec_match;

    // Equality must still hold at the tick; a rewrite cancels the reset.
    assign still_equal = |spec_match;
    assign timer_reset = pending && timer_tick && still_equal;
    // The timer uses this to skip its overflow flag on our reset.
    assign overflow_suppress = timer_reset;

    // Conversion start is one pulse on the trigger's rising edge.
    logic special_d;
    assign converter_start = special_event && !special_d &&
                             converter_enable;

    // ************************************************************
    // Pending reset register
    // ************************************************************

    // Pending drops once the reset is issued or equality is lost.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pending   <= 1'b0;
            special_d <= 1'b0;
        end
        else
        begin
            special_d <= special_event;
            pending   <= special_event && !timer_reset;
        end
    end

endmodule

// ===== sim/tcmu_timer.sv
`timescale 1ns/1ns
// ****************************************************************
// Shared timer model
// ****************************************************************
module tcmu_timer
    import tcmu_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             timer_reset,
    output tcmu_pkg::tcmu_count_t timer_count = 16'h0000,
    output logic                  timer_tick = 1'b0
);
    // Synchronous count on a halved clock, so each value lasts two cycles.
    always @(posedge clk)
    begin
        timer_tick <= ~timer_tick & ~reset;
        if (reset)
            timer_count <= 16'h0000;
        else if (timer_tick)
            timer_count <= timer_reset ? 16'h0000 : timer_count + 16'h0001;
    end
endmodule

// ===== sim/tcmu_top_assertions.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checks of the compare unit
// ****************************************************************
module tcmu_chk (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic [3:0] flag_clear,
    input wire logic       timer_tick,
    input wire logic       converter_enable,
    input wire logic [3:0] compare_match_flag,
    input wire logic [3:0] compare_output_pin,
    input wire logic [3:0] pin_owned,
    input wire logic       special_event,
    input wire logic       timer_reset,
    input wire logic       converter_start,
    input wire logic       overflow_suppress
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Strobes must trace back to a live match; the timer reset also to a timer tick.
    chk_start_cause: assert property
        (converter_start |-> special_event && converter_enable)
        else $error("start without event");
    chk_start_first: assert property
        ($rose(special_event) && converter_enable |-> converter_start)
        else $error("event without start");
    chk_reset_tick: assert property
        (timer_reset |-> timer_tick && special_event && $past(special_event))
        else $error("timer reset off tick");
    chk_reset_once: assert property (timer_reset |=> !timer_reset)
        else $error("timer reset too long");
    chk_no_overflow: assert property (overflow_suppress == timer_reset)
        else $error("overflow suppress wrong");
    // Guards on $past keep a mid-run reset from looking like a fault.
    chk_flag_sticky: assert property (!$past(reset) |->
        (~compare_match_flag & $past(compare_match_flag)
        & ~$past(flag_clear)) == 4'h0) else $error("flag lost");
    chk_pin_owned: assert property (!$past(reset) |->
        (compare_output_pin & ~$past(compare_output_pin)
        & ~$past(pin_owned)) == 4'h0) else $error("pin moved unowned");
    chk_pin_flag: assert property (!$past(reset) |->
        (compare_output_pin & ~$past(compare_output_pin)
        & ~compare_match_flag) == 4'h0) else $error("pin without flag");
    cover property (timer_reset);
    cover property (converter_start);
    cover property ($rose(compare_output_pin[0]));
endmodule
bind tcmu_top tcmu_chk chk_u (.*);

// ===== sim/tcmu_top_bench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
// ****************************************************************
// Compare unit bench
// ****************************************************************
module tcmu_top_bench;
    import tcmu_pkg::*;
    logic           clk = 1'b0;
    logic           reset = 1'b1;
    tcmu_sw_t [3:0] sw = '0;
    logic [3:0]     flag_clear = 4'h0;
    logic           converter_enable = 1'b0;
    tcmu_count_t    timer_count;
    logic           timer_tick, special_event, timer_reset;
    logic           converter_start, overflow_suppress;
    logic [3:0]     compare_match_flag, compare_output_pin, pin_owned;
    int             mismatches = 0;
    int             checks = 0;
    tcmu_sel_t      codes [5] = '{4'h8, 4'hA, 4'h2, 4'h9, 4'h8};
    logic           pins [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic           pin_direction_bit = 1'b1;
    wire logic [3:0] pad;
    logic           owns [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    int             n;
    tcmu_top dut_u (.*);
    tcmu_timer tmr_u (.*);
    always #20 clk = ~clk;
    // The pad only follows the latch once the pin is made an output.
    assign pad = pin_direction_bit ? 4'h0 : compare_output_pin;
    // Write value and select of one unit and clear its flag in one pulse.
    task automatic setup(input int u, input tcmu_sel_t c, input tcmu_count_t v);
        @(posedge clk);
        sw[u] <= '{1'b1, v, 1'b1, c};
        flag_clear[u] <= 1'b1;
        @(posedge clk);
        sw[u] <= '0;
        flag_clear <= 4'h0;
    endtask
    // Waits for the flag; two timer periods are the bound.
    task automatic hit(input int u);
        #1;
        for (n = 0; n < 400 && compare_match_flag[u] !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        `CHK("flag", 1'b1, compare_match_flag[u])
    endtask
    task automatic summarize();
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        mismatches++;
        summarize();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        converter_enable <= 1'b1;
        pin_direction_bit <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("pins", 4'h0, compare_output_pin)
        setup(3, 4'hB, 16'h0063);
        hit(3);
        `CHK("reset", 1'b1, timer_reset)
        `CHK("count", 16'h0063, timer_count)
        `CHK("owned3", 1'b0, pin_owned[3])
        `CHK("event", 1'b1, special_event)
        `CHK("suppress", 1'b1, overflow_suppress)
        @(posedge clk);
        #1;
        `CHK("wrapped", 16'h0000, timer_count)
        for (int i = 0; i < 5; i++)
        begin
            setup(i % 3, codes[i], 16'h0010 + 16'(i * 16));
            hit(i % 3);
            `CHK("owned", owns[i], pin_owned[i % 3])
            if (pins[i] !== 1'bx)
                `CHK("pin", pins[i], pad[i % 3])
        end
        setup(1, 4'h0, 16'h0010);
        #1;
        `CHK("cleared", 1'b0, compare_output_pin[1])
        // Move the period value away in the cycle the count reaches it.
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (n < 400 && !(timer_count === 16'h0062 && timer_tick));
        sw[3] <= '{1'b1, 16'h00C8, 1'b0, 4'h0};
        #1;
        `CHK("start", 1'b1, converter_start)
        @(posedge clk);
        sw[3] <= '0;
        #1;
        `CHK("cancel", 1'b0, timer_reset)
        @(posedge clk);
        #1;
        `CHK("ran on", 16'h0064, timer_count)
        summarize();
    end
endmodule
